// *** design/gyro_ctrl_cfg.svh ***
`ifndef GYRO_CTRL_CFG_SVH
`define GYRO_CTRL_CFG_SVH

//------------------------------------------------------------
// Byte addresses of the low byte of each register
//------------------------------------------------------------
`define ADR_OFFSET      7'h14
`define ADR_GAIN        7'h16
`define ADR_LINES       7'h32
`define ADR_PERIOD      7'h36
`define ADR_RANGE       7'h38
`define ADR_SLEEP       7'h3A
`define ADR_CMD         7'h3E

//------------------------------------------------------------
// Reset values
//------------------------------------------------------------
`define RST_OFFSET      16'h0000
`define RST_GAIN        16'h0800
`define RST_PERIOD      16'h0001
`define RST_RANGE       16'h0402
`define RST_SLEEP       16'h0000
`define RST_LINES       16'h0000

//------------------------------------------------------------
// Readable bit masks (unused bits read zero)
//------------------------------------------------------------
`define MSK_OFFSET      16'h0FFF
`define MSK_GAIN        16'h0FFF
`define MSK_PERIOD      16'h00FF
`define MSK_RANGE       16'h0787
`define MSK_SLEEP       16'h00FF
`define MSK_LINES       16'h0303

//------------------------------------------------------------
// Field positions
//------------------------------------------------------------
`define PER_TB          7
`define RNG_POLE        7
`define CMD_RESET       7
`define CMD_FLASH       3
`define CMD_DAC         2
`define CMD_FACT        1
`define CMD_NULL        0
`define WR_FLAG         15
`define LINE_DIR        0
`define LINE_LVL        8

//------------------------------------------------------------
// Encodings
//------------------------------------------------------------
`define RANGE_320       3'b100
`define RANGE_160       3'b010
`define RANGE_80        3'b001
`define TAP_MIN_160     3'h2
`define TAP_MIN_80      3'h4
`define LOW_PWR_MIN     8'h08

//------------------------------------------------------------
// Timing in own units
//------------------------------------------------------------
`define CLK_NS          40
`define TB_FAST_NS      1953000
`define TB_SLOW_NS      60540000
`define FAST_SPS        2048
`define SLEEP_LSB_MS    500
`define BOOT_NS         1000000

`endif

// *** design/gyro_ctrl_pkg.sv ***
package gyro_ctrl_pkg;

	// Core operating mode
	typedef enum logic [2:0] {
		MODE_RUN   = 3'b001,
		MODE_BOOT  = 3'b010,
		MODE_SLEEP = 3'b100
	} mode_type;

	// Claim of the two digital lines by a higher owner
	typedef struct packed {
		logic [1:0] own;
		logic [1:0] level;
	} line_claim_type;

endpackage : gyro_ctrl_pkg

// *** design/gyro_operational_controls.sv ***
`timescale 1ns/10ps
`include "gyro_ctrl_cfg.svh"

// Functional notes
// - period low byte zero gives 2048 SPS
// - otherwise period is time base times (N+1)
// - range code 100/010/001 gives 320/160/80
// - reduced ranges raise taps to 2 or 4
// - pole bit selects wide or narrow bandwidth
// - two cascaded 2^m moving averages
// - add 12-bit signed offset, quarter LSB
// - multiply by unsigned 12-bit gain, 0x800 unity
// - trigger bits self-clear when done
// - soft reset reloads saved copy, reboots
// - flash, DAC latch, factory, autonull triggers
// - period byte 0x08 up enters low power
// - sleep for count times half second
// - line owners: misc, alert, then general
// - general bits 1:0 set line directions
// - general bits 9:8 set line levels
module gyro_operational_controls
	import gyro_ctrl_pkg::*;
#(
	parameter int FAST_CYC  = 1000000000 / `FAST_SPS / `CLK_NS,
	parameter int TBF_CYC   = `TB_FAST_NS / `CLK_NS,
	parameter int TBS_CYC   = `TB_SLOW_NS / `CLK_NS,
	parameter int HALF_CYC  = `SLEEP_LSB_MS * 1000000 / `CLK_NS,
	parameter int BOOT_CYC  = `BOOT_NS / `CLK_NS,
	parameter int RW        = 14
) (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// Serial port
	input  wire logic                 sclk,
	input  wire logic                 cs_n,
	input  wire logic                 mosi,
	output logic                      miso,
	// Sensor data
	input  wire logic signed [RW-1:0] raw_rate,
	output logic                      sample_tick,
	output logic signed [RW-1:0]      rate_out,
	output logic                      rate_valid,
	// Front end and power
	output logic [2:0]                range_sel,
	output logic                      pole_wide,
	output logic                      low_power,
	output logic                      sleeping,
	output logic                      sensing,
	// External operations
	output logic                      start_dac,
	output logic                      start_null,
	input  wire logic                 dac_done,
	input  wire logic                 null_done,
	// Digital lines
	input  wire line_claim_type       misc_claim,
	input  wire line_claim_type       alert_claim,
	input  wire logic [1:0]           line_i,
	output logic [1:0]                line_o,
	output logic [1:0]                line_oe
);

	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	logic [15:0] offset_trim, gain_trim, period, range_filt;
	logic [15:0] sleep_dur, line_ctl, cmd;
	logic [15:0] nv_offset, nv_gain, nv_period, nv_range, nv_sleep;
	mode_type    mode;

	// Tap floor for the reduced ranges
	function automatic logic [2:0] tap_floor(input logic [2:0] rng,
	                                         input logic [2:0] taps);
		logic [2:0] lo;
		lo = 3'h0;
		if (rng == `RANGE_160)
			lo = `TAP_MIN_160;
		else if (rng == `RANGE_80)
			lo = `TAP_MIN_80;
		tap_floor = (taps < lo) ? lo : taps;
	endfunction : tap_floor

	//------------------------------------------------------------
	// Serial port
	//------------------------------------------------------------
	logic        sclk_q;
	logic [3:0]  bit_cnt;
	logic [15:0] rx_sr, tx_sr;
	wire         rise   = sclk & ~sclk_q & ~cs_n;
	wire         fall   = ~sclk & sclk_q & ~cs_n;
	wire [15:0]  word   = {rx_sr[14:0], mosi};
	wire         frame  = rise && bit_cnt == 4'hF;
	// flag, address and data byte split
	wire         wr_stb = frame & word[`WR_FLAG];
	wire         rd_stb = frame & ~word[`WR_FLAG];
	wire [6:0]   adr    = word[14:8];
	wire [7:0]   din    = word[7:0];
	wire [6:0]   adr_lo = {adr[6:1], 1'b0};
	wire         hi     = adr[0];

	// Sample on rising edge, shift out on falling edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclk_q  <= 1'b1;
			bit_cnt <= 4'h0;
			rx_sr   <= 16'h0000;
		end else begin
			sclk_q <= sclk;
			if (cs_n)
				bit_cnt <= 4'h0;
			else if (rise) begin
				bit_cnt <= bit_cnt + 4'h1;
				rx_sr   <= word;
			end
		end
	end

	// Line levels seen by software: pin when input
	// input line reads the pin level
	wire [1:0]  lvl_rd = (line_ctl[1:0] & line_ctl[9:8]) | (~line_ctl[1:0] & line_i);

	// Read data decode, addressed by the low byte address
	// unused bits read as zero
	wire [15:0] rd_data =
		(adr_lo == `ADR_OFFSET) ? (offset_trim & `MSK_OFFSET) :
		(adr_lo == `ADR_GAIN)   ? (gain_trim   & `MSK_GAIN)   :
		(adr_lo == `ADR_PERIOD) ? (period      & `MSK_PERIOD) :
		(adr_lo == `ADR_RANGE)  ? (range_filt  & `MSK_RANGE)  :
		(adr_lo == `ADR_SLEEP)  ? (sleep_dur   & `MSK_SLEEP)  :
		(adr_lo == `ADR_LINES)  ? {6'h00, lvl_rd, 6'h00, line_ctl[1:0]} :
		16'h0000;

	// Read answer goes out in the following frame, MSB first
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_sr <= 16'h0000;
			miso  <= 1'b0;
		end else if (rd_stb) begin
			tx_sr <= {rd_data[14:0], 1'b0};
			miso  <= rd_data[15];
		end else if (fall && bit_cnt != 4'h0) begin
			tx_sr <= {tx_sr[14:0], 1'b0};
			miso  <= tx_sr[15];
		end
	end

	//------------------------------------------------------------
	// Register writes and commands
	//------------------------------------------------------------
	// each byte lands on its own address
	wire wr_off  = wr_stb && adr_lo == `ADR_OFFSET;
	wire wr_gain = wr_stb && adr_lo == `ADR_GAIN;
	wire wr_per  = wr_stb && adr_lo == `ADR_PERIOD;
	wire wr_rng  = wr_stb && adr_lo == `ADR_RANGE;
	wire wr_slp  = wr_stb && adr_lo == `ADR_SLEEP && !hi;
	wire wr_line = wr_stb && adr_lo == `ADR_LINES;
	wire wr_cmd  = wr_stb && adr_lo == `ADR_CMD && !hi;
	wire [7:0] cmd_set = wr_cmd ? din : 8'h00;

	// Operation status
	logic [23:0] boot_cnt;
	wire         boot_end = mode == MODE_BOOT && boot_cnt == 24'h0;

	// Updated range byte and tap byte, floor applied either way
	// reduced range forces a minimum tap count
	wire [2:0] new_rng  = (wr_rng && hi) ? din[2:0] : range_filt[10:8];
	wire [2:0] new_tap  = (wr_rng && !hi) ? din[2:0] : range_filt[2:0];
	wire [7:0] new_rlo  = (wr_rng && !hi) ? din : range_filt[7:0];
	wire [15:0] next_range = {5'h00, new_rng, new_rlo[7:3], tap_floor(new_rng, new_tap)};

	// Byte merge shared by all plain registers
	function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] msk,
	                                      input logic h, input logic [7:0] d);
		merge = (h ? {d, cur[7:0]} : {cur[15:8], d}) & msk;
	endfunction : merge

	// Control registers; reload and restore win over a write
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			offset_trim <= `RST_OFFSET;
			gain_trim   <= `RST_GAIN;
			period      <= `RST_PERIOD;
			range_filt  <= `RST_RANGE;
			sleep_dur   <= `RST_SLEEP;
			line_ctl    <= `RST_LINES;
		end else begin
			if (wr_off)
				offset_trim <= merge(offset_trim, `MSK_OFFSET, hi, din);
			if (wr_gain)
				gain_trim <= merge(gain_trim, `MSK_GAIN, hi, din);
			if (wr_per)
				period <= merge(period, `MSK_PERIOD, hi, din);
			if (wr_rng)
				range_filt <= next_range & `MSK_RANGE;
			if (wr_slp)
				sleep_dur <= merge(sleep_dur, `MSK_SLEEP, hi, din);
			if (wr_line)
				line_ctl <= merge(line_ctl, `MSK_LINES, hi, din);
			if (cmd[`CMD_FACT]) begin
				offset_trim <= `RST_OFFSET;
				gain_trim   <= `RST_GAIN;
			end
			// reload from saved copy on soft reset
			if (cmd_set[`CMD_RESET]) begin
				offset_trim <= nv_offset;
				gain_trim   <= nv_gain;
				period      <= nv_period;
				range_filt  <= nv_range;
				sleep_dur   <= nv_sleep;
			end
		end
	end

	// Saved copy, refreshed by flash update or factory restore
	// flash update stores the settings
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			nv_offset <= `RST_OFFSET;
			nv_gain   <= `RST_GAIN;
			nv_period <= `RST_PERIOD;
			nv_range  <= `RST_RANGE;
			nv_sleep  <= `RST_SLEEP;
		end else if (cmd[`CMD_FACT]) begin
			nv_offset <= `RST_OFFSET;
			nv_gain   <= `RST_GAIN;
		end else if (cmd[`CMD_FLASH]) begin
			nv_offset <= offset_trim;
			nv_gain   <= gain_trim;
			nv_period <= period;
			nv_range  <= range_filt;
			nv_sleep  <= sleep_dur;
		end
	end

	// Completion of each trigger; flash and restore take one cycle
	wire [7:0] cmd_done = {boot_end, 3'b000, cmd[`CMD_FLASH], dac_done,
	                       cmd[`CMD_FACT], null_done};

	// Trigger bits: a new set wins over a completion
	// trigger bits clear themselves on completion
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd        <= 16'h0000;
			start_dac  <= 1'b0;
			start_null <= 1'b0;
		end else begin
			cmd        <= {8'h00, (cmd[7:0] & ~cmd_done) | (cmd_set & 8'h8F)};
			start_dac  <= cmd_set[`CMD_DAC];
			start_null <= cmd_set[`CMD_NULL];
		end
	end

	//------------------------------------------------------------
	// Operating mode: boot, run, sleep
	//------------------------------------------------------------
	logic [23:0] half_cnt;
	logic [7:0]  slp_left;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode     <= MODE_RUN;
			boot_cnt <= 24'h0;
			half_cnt <= 24'h0;
			slp_left <= 8'h00;
		end else begin
			unique case (mode)
				MODE_RUN: begin
					if (wr_slp && din != 8'h00) begin
						mode     <= MODE_SLEEP;
						slp_left <= din;
						half_cnt <= 24'(HALF_CYC - 1);
					end
				end
				MODE_SLEEP: begin
					if (half_cnt != 24'h0)
						half_cnt <= half_cnt - 24'h1;
					else if (slp_left == 8'h01)
						mode <= MODE_RUN;
					else begin
						slp_left <= slp_left - 8'h01;
						half_cnt <= 24'(HALF_CYC - 1);
					end
				end
				MODE_BOOT: begin
					if (boot_cnt != 24'h0)
						boot_cnt <= boot_cnt - 24'h1;
					else
						mode <= MODE_RUN;
				end
			endcase
			// soft reset halts sensing and reboots
			if (cmd_set[`CMD_RESET]) begin
				mode     <= MODE_BOOT;
				boot_cnt <= 24'(BOOT_CYC - 1);
			end
		end
	end

	//------------------------------------------------------------
	// Sample period generator
	//------------------------------------------------------------
	logic [20:0] base_cnt;
	logic [6:0]  step_cnt;
	wire         fast     = period[7:0] == 8'h00;
	wire [20:0]  base_top = fast ? 21'(FAST_CYC - 1) :
	                        period[`PER_TB] ? 21'(TBS_CYC - 1) : 21'(TBF_CYC - 1);
	wire         base_end = base_cnt >= base_top;
	// zero period byte ticks every base wrap
	wire         tick_now = base_end && (fast || step_cnt >= period[6:0]);
	wire         running  = mode == MODE_RUN;

	// Counts base periods, then N+1 of them per sample
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			base_cnt    <= 21'h0;
			step_cnt    <= 7'h00;
			sample_tick <= 1'b0;
		end else begin
			sample_tick <= running & tick_now;
			if (!running || base_end)
				base_cnt <= 21'h0;
			else
				base_cnt <= base_cnt + 21'h1;
			if (!running || tick_now)
				step_cnt <= 7'h00;
			else if (base_end)
				step_cnt <= step_cnt + 7'h01;
		end
	end

	// Front end controls and status flags
	// range code passed to the front end
	// pole bit sets front end bandwidth
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			range_sel <= 3'(`RST_RANGE >> 8);
			pole_wide <= 1'b0;
			low_power <= 1'b0;
			sleeping  <= 1'b0;
			sensing   <= 1'b1;
		end else begin
			range_sel <= range_filt[10:8];
			pole_wide <= range_filt[`RNG_POLE];
			low_power <= period[7:0] >= `LOW_PWR_MIN;
			sleeping  <= mode == MODE_SLEEP;
			sensing   <= running;
		end
	end

	//------------------------------------------------------------
	// Two cascaded moving averages
	//------------------------------------------------------------
	logic [2:0]           taps_q;
	wire  [2:0]           taps    = range_filt[2:0];
	wire                  flush   = !running || taps != taps_q;
	wire  [7:0]           n_taps  = 8'h01 << taps;
	logic signed [RW-1:0] st_in  [0:2];
	logic                 st_vld [0:2];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			taps_q <= 3'(`RST_RANGE);
		else
			taps_q <= taps;
	end

	assign st_in[0]  = raw_rate;
	assign st_vld[0] = sample_tick;

	// Each stage has its own ring of depth 128, which covers the largest tap count
	// each stage averages 2^m samples
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : stage
			logic signed [RW-1:0]  mem [0:127];
			logic [6:0]            wp;
			logic [7:0]            fill;
			logic signed [RW+6:0]  acc;
			logic signed [RW-1:0]  avg;
			logic                  vld;
			wire  [6:0]            rp  = wp - n_taps[6:0];
			wire  signed [RW-1:0]  old = (fill >= n_taps) ? mem[rp] : '0;
			wire  signed [RW+6:0]  sum = acc + (RW+7)'(st_in[g]) - (RW+7)'(old);

			always_ff @(posedge clk) begin
				if (st_vld[g])
					mem[wp] <= st_in[g];
			end

			// Flushed on tap change so stale samples never leak in
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					wp   <= 7'h00;
					fill <= 8'h00;
					acc  <= '0;
					avg  <= '0;
					vld  <= 1'b0;
				end else if (flush) begin
					wp   <= 7'h00;
					fill <= 8'h00;
					acc  <= '0;
					vld  <= 1'b0;
				end else begin
					vld <= st_vld[g];
					if (st_vld[g]) begin
						wp   <= wp + 7'h01;
						fill <= (fill == 8'h80) ? fill : fill + 8'h01;
						acc  <= sum;
						avg  <= RW'(sum >>> taps);
					end
				end
			end

			assign st_in[g+1]  = avg;
			assign st_vld[g+1] = vld;
		end
	endgenerate

	//------------------------------------------------------------
	// Offset and gain calibration
	//------------------------------------------------------------
	// offset in quarter rate steps, sign extended
	wire signed [RW+2:0]  with_off = ((RW+3)'(st_in[2]) <<< 2) +
	                                 (RW+3)'($signed(offset_trim[11:0]));
	wire signed [RW+15:0] scaled   = with_off * $signed({1'b0, gain_trim[11:0]});
	wire signed [RW+2:0]  trimmed  = (RW+3)'(scaled >>> 13);
	wire signed [RW+2:0]  max_v    = (RW+3)'({1'b0, {(RW-1){1'b1}}});
	wire signed [RW+2:0]  min_v    = -max_v - (RW+3)'(1);
	wire signed [RW-1:0]  clipped  = (trimmed > max_v) ? RW'(max_v) :
	                                 (trimmed < min_v) ? RW'(min_v) : RW'(trimmed);

	// Saturate rather than wrap; wrap would flip sign at full scale
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rate_out   <= '0;
			rate_valid <= 1'b0;
		end else begin
			rate_valid <= st_vld[2];
			if (st_vld[2])
				rate_out <= clipped;
		end
	end

	//------------------------------------------------------------
	// Digital lines
	//------------------------------------------------------------
	// misc owner first, alert next, general last
	wire [1:0] gp_oe  = line_ctl[1:0];
	wire [1:0] next_o = (misc_claim.own & misc_claim.level) |
	                    (~misc_claim.own & alert_claim.own & alert_claim.level) |
	                    (~misc_claim.own & ~alert_claim.own & line_ctl[9:8]);
	wire [1:0] next_oe = misc_claim.own | alert_claim.own | gp_oe;

	// Input lines are never driven by a level write
	// level write has no effect on inputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			line_o  <= 2'b00;
			line_oe <= 2'b00;
		end else begin
			line_o  <= next_o & next_oe;
			line_oe <= next_oe;
		end
	end

endmodule : gyro_operational_controls

// *** test/gyro_ctrl_assertions.sv ***
`timescale 1ns/10ps
// Port watcher for the control block; one clock domain
module gyro_ctrl_checker
	import gyro_ctrl_pkg::*;
(
	// Clock and reset
	input wire logic           clk,
	input wire logic           rstn,
	// Sensor timing
	input wire logic           sample_tick,
	input wire logic           rate_valid,
	input wire logic [2:0]     range_sel,
	input wire logic           sleeping,
	input wire logic           sensing,
	// Operations
	input wire logic           start_dac,
	input wire logic           start_null,
	// Lines
	input wire line_claim_type misc_claim,
	input wire logic [1:0]     line_o,
	input wire logic [1:0]     line_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_range_code;
		$onehot(range_sel);
	endproperty
	a_range_code: assert property (p_range_code) else $error("range select not one-hot");
	// Shortest period is twenty cycles, so eight quiet cycles is safe
	property p_tick_gap;
		sample_tick |=> !sample_tick [*8];
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("sample ticks too close");
	property p_tick_run;
		sample_tick |-> sensing;
	endproperty
	a_tick_run: assert property (p_tick_run) else $error("sample tick while halted");
	property p_valid_lat;
		rate_valid |-> $past(sample_tick, 3);
	endproperty
	a_valid_lat: assert property (p_valid_lat) else $error("rate valid without tick");
	property p_dac_pulse;
		start_dac |=> !start_dac;
	endproperty
	a_dac_pulse: assert property (p_dac_pulse) else $error("dac start too long");
	property p_null_pulse;
		start_null |=> !start_null;
	endproperty
	a_null_pulse: assert property (p_null_pulse) else $error("null start too long");
	property p_sleep_quiet;
		sleeping |-> !sensing;
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("sensing while asleep");
	property p_wake;
		$fell(sensing) |-> ##[1:300] sensing;
	endproperty
	a_wake: assert property (p_wake) else $error("sensing did not resume");
	property p_misc_own;
		misc_claim.own[0] |=> line_oe[0] && line_o[0] == $past(misc_claim.level[0]);
	endproperty
	a_misc_own: assert property (p_misc_own) else $error("line one not given to misc");
	property p_idle_low;
		!line_oe[1] |-> !line_o[1];
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("undriven line two high");
	c_dac: cover property (start_dac);
	c_sleep: cover property ($rose(sleeping));
	c_boot: cover property ($fell(sensing) && !sleeping);
endmodule : gyro_ctrl_checker

// *** test/spi_host_model.sv ***
`timescale 1ns/10ps
// Host side of the serial port: mode 3, three clocks per serial level
module spi_host_model (
	// Clock
	input  wire logic clk,
	// Serial port
	output logic      sclk,
	output logic      cs_n,
	output logic      mosi,
	input  wire logic miso
);
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(negedge clk);
		cs_n = 1'b0;
		for (int k = 15; k >= 0; k--) begin
			sclk = 1'b0;
			mosi = w[k];
			repeat (3) @(negedge clk);
			r[k] = miso;
			sclk = 1'b1;
			repeat (3) @(negedge clk);
		end
		// Released data shows the inverse so a stale bit is never trusted
		cs_n = 1'b1;
		mosi = ~mosi;
		repeat (3) @(negedge clk);
	endtask : xfer
endmodule : spi_host_model

// *** test/test_gyro_operational_controls.sv ***
`timescale 1ns/10ps
`include "gyro_ctrl_cfg.svh"
module test_gyro_operational_controls;
	import gyro_ctrl_pkg::*;
	localparam int BOOT = 8;
	localparam int HALF = 16;
	localparam logic [6:0] radr [8] = '{`ADR_PERIOD, `ADR_RANGE, `ADR_OFFSET, `ADR_GAIN,
		`ADR_SLEEP, `ADR_LINES, `ADR_CMD, 7'h40};
	localparam logic [15:0] rrst [8] = '{16'h0001, 16'h0402, 16'h0000, 16'h0800,
		16'h0000, 16'h0300, 16'h0000, 16'h0000};
	localparam logic [7:0] pcode [4] = '{8'h00, 8'h04, 8'h81, 8'h09};
	localparam int pcyc [4] = '{20, 50, 60, 100};
	logic clk, rstn, sclk, cs_n, mosi, miso, sample_tick, rate_valid, pole_wide;
	logic low_power, sleeping, sensing, start_dac, start_null, dac_done, null_done;
	logic signed [13:0] raw_rate, rate_out;
	logic [2:0]         range_sel;
	logic [1:0]         line_i, line_o, line_oe;
	line_claim_type     misc_claim, alert_claim;
	logic [31:0]        s;
	logic [15:0]        d;
	logic [11:0]        o, g;
	int bad_count = 0, comparisons = 0, boot_n = 0, sleep_n = 0, n;
	int op_n [2] = '{0, 0};

	gyro_operational_controls #(.FAST_CYC(20), .TBF_CYC(10), .TBS_CYC(30), .HALF_CYC(HALF),
		.BOOT_CYC(BOOT)) gyro_operational_controls_i (.clk(clk), .rstn(rstn), .sclk(sclk),
		.cs_n(cs_n), .mosi(mosi), .miso(miso), .raw_rate(raw_rate), .sample_tick(sample_tick),
		.rate_out(rate_out), .rate_valid(rate_valid), .range_sel(range_sel),
		.pole_wide(pole_wide), .low_power(low_power), .sleeping(sleeping), .sensing(sensing),
		.start_dac(start_dac), .start_null(start_null), .dac_done(dac_done),
		.null_done(null_done), .misc_claim(misc_claim), .alert_claim(alert_claim),
		.line_i(line_i), .line_o(line_o), .line_oe(line_oe));
	spi_host_model spi_host_model_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso));

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	// Trimmed rate; offset LSB is a quarter of a rate LSB
	function automatic logic [13:0] exp_rate(input int x, input logic [11:0] f, input logic [11:0] k);
		int p;
		p = (x * 4 + int'($signed(f))) * int'(k);
		return 14'(p >>> 13);
	endfunction : exp_rate
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [15:0] r;
		spi_host_model_i.xfer({1'b1, a, v}, r);
	endtask : wr
	// Read answer arrives in the following frame
	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		spi_host_model_i.xfer({1'b0, a, 8'h00}, v);
		spi_host_model_i.xfer(16'h0000, v);
	endtask : rd
	task automatic gap(output int c);
		for (int i = 0; i < 500 && sample_tick !== 1'b1; i++)
			@(negedge clk);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (sample_tick !== 1'b1 && c < 500);
	endtask : gap
	task automatic wv();
		@(negedge clk);
		for (int i = 0; i < 300 && rate_valid !== 1'b1; i++)
			@(negedge clk);
		check({15'h0, rate_valid}, 16'h0001);
	endtask : wv
	task automatic test_done();
		$display("counts: bad=%0d comparisons=%0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// Level and pulse counters, read at the settled falling edge
	always @(negedge clk) begin
		if (rstn === 1'b1 && sensing === 1'b0 && sleeping === 1'b0)
			boot_n++;
		if (sleeping === 1'b1)
			sleep_n++;
		if (start_null === 1'b1)
			op_n[0]++;
		if (start_dac === 1'b1)
			op_n[1]++;
	end
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Watchdog sized well above the whole sequence
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		test_done();
	end
	initial begin
		rstn = 1'b0;
		raw_rate = '0;
		{dac_done, null_done} = 2'b00;
		misc_claim = '0;
		alert_claim = '0;
		line_i = 2'b11;
		s = 32'hfccd;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		check({13'h0, range_sel}, 16'h0004);
		foreach (radr[i]) begin
			rd(radr[i], d);
			check(d, rrst[i]);
		end
		for (int i = 0; i < 3; i++) begin
			wr(`ADR_RANGE + 7'h1, {5'h0, 3'(3'b100 >> i)});
			wr(`ADR_RANGE, 8'h80);
			rd(`ADR_RANGE, d);
			check(d, {5'h0, 3'(3'b100 >> i), 5'h10, 3'(2 * i)});
			check({13'h0, range_sel}, {13'h0, 3'(3'b100 >> i)});
			check({15'h0, pole_wide}, 16'h0001);
		end
		wr(`ADR_RANGE + 7'h1, 8'h04);
		wr(`ADR_RANGE, 8'h00);
		check({15'h0, pole_wide}, 16'h0000);
		foreach (pcode[i]) begin
			wr(`ADR_PERIOD, pcode[i]);
			gap(n);
			gap(n);
			check(16'(n), 16'(pcyc[i]));
			check({15'h0, low_power}, {15'h0, pcode[i] >= 8'h08});
		end
		wr(`ADR_PERIOD, 8'h01);
		// Random trims; corner rows: unity gain, most negative offset, zero gain
		for (int i = 0; i < 5; i++) begin
			s = lfsr(s);
			g = (i == 0) ? 12'h800 : (i == 2) ? 12'h000 : s[11:0];
			o = (i == 1) ? 12'h800 : s[31:20];
			raw_rate = 14'($signed(s[9:0]));
			wr(`ADR_OFFSET + 7'h1, {s[15:12], o[11:8]});
			wr(`ADR_OFFSET, o[7:0]);
			wr(`ADR_GAIN + 7'h1, {s[15:12], g[11:8]});
			wr(`ADR_GAIN, g[7:0]);
			rd(`ADR_OFFSET, d);
			check(d, {4'h0, o});
			wv();
			wv();
			check({2'b00, rate_out}, {2'b00, exp_rate(int'(raw_rate), o, g)});
		end
		wr(`ADR_LINES + 7'h1, 8'h03);
		wr(`ADR_LINES, 8'h02);
		check({12'h0, line_oe, line_o}, 16'h000a);
		rd(`ADR_LINES, d);
		check(d, 16'h0302);
		misc_claim = '{own: 2'b01, level: 2'b01};
		alert_claim = '{own: 2'b11, level: 2'b00};
		repeat (3) @(negedge clk);
		check({12'h0, line_oe, line_o}, 16'h000d);
		misc_claim = '0;
		alert_claim = '0;
		for (int i = 0; i < 2; i++) begin
			n = op_n[i];
			wr(`ADR_CMD, i ? 8'h04 : 8'h01);
			{dac_done, null_done} = 2'(1 << i);
			@(negedge clk);
			{dac_done, null_done} = 2'b00;
			check(16'(op_n[i] - n), 16'h0001);
		end
		wr(`ADR_OFFSET, 8'h55);
		wr(`ADR_CMD, 8'h02);
		rd(`ADR_OFFSET, d);
		check(d, 16'h0000);
		rd(`ADR_GAIN, d);
		check(d, 16'h0800);
		wr(`ADR_PERIOD, 8'h05);
		wr(`ADR_CMD, 8'h08);
		wr(`ADR_PERIOD, 8'h00);
		n = boot_n;
		wr(`ADR_CMD, 8'h80);
		repeat (BOOT + 4) @(negedge clk);
		check(16'(boot_n - n), 16'(BOOT));
		rd(`ADR_PERIOD, d);
		check(d, 16'h0005);
		n = sleep_n;
		wr(`ADR_SLEEP, 8'h02);
		repeat (2 * HALF + 4) @(negedge clk);
		check(16'(sleep_n - n), 16'(2 * HALF));
		rd(`ADR_SLEEP, d);
		check(d, 16'h0002);
		test_done();
	end
endmodule : test_gyro_operational_controls

bind gyro_operational_controls gyro_ctrl_checker gyro_ctrl_checker_i (.clk(clk), .rstn(rstn),
	.sample_tick(sample_tick), .rate_valid(rate_valid), .range_sel(range_sel),
	.sleeping(sleeping), .sensing(sensing), .start_dac(start_dac), .start_null(start_null),
	.misc_claim(misc_claim), .line_o(line_o), .line_oe(line_oe));
